// ===== hdl/vtinv_pkg.sv
// Package for the tagged translation invalidate block
package vtinv_pkg;
  localparam int unsigned TYPE_W = 64;
  localparam logic [63:0] TYPE_INDIV = 64'h0;
  localparam logic [63:0] TYPE_SINGLE = 64'h1;
  localparam logic [63:0] TYPE_ALL = 64'h2;
  localparam logic [63:0] TYPE_KEEP_GLB = 64'h3;
  localparam int unsigned TAG_LSB = 0;
  localparam int unsigned TAG_W = 16;
  localparam int unsigned RSVD_LSB = 16;
  localparam int unsigned RSVD_W = 48;
  localparam int unsigned LADDR_LSB = 64;
  localparam int unsigned LADDR_W = 64;
  localparam int unsigned VADDR_W = 48;
  localparam int unsigned CTLS2_TAG_BIT = 37;
  localparam int unsigned CTLS2_NEST_BIT = 33;
  localparam int unsigned CAP_TAGINV_BIT = 32;
  localparam int unsigned CAP_NESTINV_BIT = 20;
  localparam logic [4:0] ERR_INVALID_OPERAND = 5'h1c;
  localparam logic [15:0] FAULT_CODE_ZERO = 16'h0000;
  localparam int unsigned FAULT_W = 3;
  typedef enum logic [2:0] {
    VTINV_FLT_NONE = 3'h0,
    VTINV_FLT_UD = 3'h1,
    VTINV_FLT_GP = 3'h2,
    VTINV_FLT_SS = 3'h3,
    VTINV_FLT_PF = 3'h4
  } vtinv_fault_type;
  typedef enum logic [1:0] {
    VTINV_ST_IDLE = 2'h0,
    VTINV_ST_FETCH = 2'h1,
    VTINV_ST_INVAL = 2'h2
  } vtinv_state_type;
endpackage

// ===== hdl/vtinv_chk_if.sv
// Interface between the sequencer and the descriptor checker
`timescale 1ns/10ps
`default_nettype none
interface vtinv_chk_if;
  logic [127:0] desc;
  logic [1:0] kind;
  logic fail;
  modport checker_side (input desc, input kind, output fail);
  modport seq_side (output desc, output kind, input fail);
endinterface
`default_nettype wire

// ===== hdl/vtinv_desc_chk.sv
// Descriptor checks for the tagged invalidate
`timescale 1ns/10ps
`default_nettype none
module vtinv_desc_chk (
  vtinv_chk_if.checker_side chk
);
  import vtinv_pkg::*;
  logic rsvd_bad;
  logic tag_zero;
  logic non_canon;
  always_comb begin
    rsvd_bad = |chk.desc[RSVD_LSB +: RSVD_W]; // [R07]
    tag_zero = (chk.desc[TAG_LSB +: TAG_W] == 16'h0000);
    // Canonical means bits 63:47 all equal
    non_canon = !((&chk.desc[LADDR_LSB + VADDR_W - 1 +: 17]) || ~(|chk.desc[LADDR_LSB + VADDR_W - 1 +: 17]));
    chk.fail = rsvd_bad
      || (tag_zero && (chk.kind != 2'h2)) // [R08]
      || (non_canon && (chk.kind == 2'h0)); // [R09]
  end
endmodule
`default_nettype wire

// ===== hdl/vtinv_top.sv
// Tagged translation invalidate execution and checking
// What this block does
// R01 - Type 0 invalidates the descriptor address under the descriptor tag.
// R02 - Type 1 invalidates every mapping with the descriptor tag.
// R03 - Type 2 invalidates all mappings with nonzero tags.
// R04 - Type 3 invalidates the tag's mappings except global ones.
// R05 - Unsupported type reports invalid operand, no invalidation.
// R06 - Descriptor is 128 bits: tag low 16, address upper half.
// R07 - Nonzero descriptor bits 63:16 report invalid operand.
// R08 - Zero tag fails for types 0, 1 and 3.
// R09 - Type 0 with non-canonical address reports invalid operand.
// R10 - Invalidation ignores nested pointer and process tag values.
// R11 - Type operand is 32 bits outside long mode, 64 in 64-bit mode.
// R12 - Undefined opcode in v86, outside virtualization, or protection off.
// R13 - Undefined opcode in compatibility mode.
// R14 - Guest operation exits to the monitor after opcode checks.
// R15 - Root operation with privilege above zero gives protection fault 0.
// R16 - Page fault on descriptor fetch is raised with its code.
// R17 - Stack limit or unusable stack gives stack fault; else protection.
// R18 - 64-bit non-canonical address: protection or stack fault by segment.
// R19 - Nested invalidate needs capability bits 33 and 20 else undefined.
// R20 - Success clears flags; fail sets carry, or zero and error number.
// R21 - Tagged invalidate needs capability bits 37 and 32 else undefined.
// R22 - Per-type support vector is consulted before descriptor fetch.
`timescale 1ns/10ps
`default_nettype none
module vtinv_top (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic issue_valid,
  input wire logic issue_is_nested,
  input wire logic [63:0] type_operand,
  input wire logic vmx_on,
  input wire logic guest_mode,
  input wire logic protection_enable_flag,
  input wire logic v86_mode_flag,
  input wire logic long_mode_active_flag,
  input wire logic cs_long,
  input wire logic [1:0] current_privilege_level,
  input wire logic [63:0] secondary_ctl_capabilities,
  input wire logic [63:0] translation_inval_capabilities,
  input wire logic [3:0] type_supported,
  input wire logic current_struct_valid,
  output logic fetch_req,
  input wire logic fetch_done,
  input wire logic [127:0] fetch_data,
  input wire logic fetch_pf,
  input wire logic [15:0] fetch_pf_code,
  input wire logic fetch_limit_ss,
  input wire logic fetch_limit_other,
  output logic inval_valid,
  output logic [1:0] inval_kind,
  output logic [15:0] inval_tag,
  output logic [63:0] inval_addr,
  input wire logic inval_ack,
  output logic done,
  output logic vm_exit,
  output vtinv_pkg::vtinv_fault_type fault,
  output logic [15:0] fault_code,
  output logic [5:0] flags_out,
  output logic err_write,
  output logic [4:0] err_number
);
  import vtinv_pkg::*;
  vtinv_state_type state_q, state_d;
  logic [1:0] kind_q, kind_d;
  logic [127:0] desc_q, desc_d;
  logic done_q, done_d;
  logic vm_exit_q, vm_exit_d;
  vtinv_fault_type fault_q, fault_d;
  logic [15:0] fcode_q, fcode_d;
  logic [5:0] flags_q, flags_d;
  logic err_wr_q, err_wr_d;
  logic [4:0] err_q, err_d;
  logic [63:0] eff_type;
  logic type_ok;
  logic ud_hit;
  logic cap_miss;
  logic desc_fail;
  vtinv_chk_if chk_bus ();
  vtinv_desc_chk u_chk (
    .chk(chk_bus.checker_side)
  );
  assign chk_bus.desc = fetch_data;
  assign chk_bus.kind = kind_q;
  assign desc_fail = chk_bus.fail;
  // Flag order: {of, sf, zf, af, pf, cf}
  always_comb begin
    // Upper half ignored unless in 64-bit mode
    eff_type = (long_mode_active_flag && cs_long) ? type_operand : {32'h0, type_operand[31:0]}; // [R11]
    type_ok = (eff_type[63:2] == 62'h0) && type_supported[eff_type[1:0]]; // [R22]
    cap_miss = issue_is_nested
      ? !(secondary_ctl_capabilities[CTLS2_NEST_BIT] && translation_inval_capabilities[CAP_NESTINV_BIT]) // [R19]
      : !(secondary_ctl_capabilities[CTLS2_TAG_BIT] && translation_inval_capabilities[CAP_TAGINV_BIT]); // [R21]
    ud_hit = !vmx_on || !protection_enable_flag || v86_mode_flag // [R12]
      || (long_mode_active_flag && !cs_long) // [R13]
      || cap_miss;
  end
  always_comb begin
    state_d = state_q;
    kind_d = kind_q;
    desc_d = desc_q;
    done_d = 1'b0;
    vm_exit_d = 1'b0;
    fault_d = VTINV_FLT_NONE;
    fcode_d = FAULT_CODE_ZERO;
    flags_d = flags_q;
    err_wr_d = 1'b0;
    err_d = err_q;
    case (state_q)
      VTINV_ST_IDLE: begin
        if (issue_valid) begin
          kind_d = eff_type[1:0];
          if (ud_hit) begin
            done_d = 1'b1;
            fault_d = VTINV_FLT_UD;
          end else if (guest_mode) begin
            done_d = 1'b1;
            vm_exit_d = 1'b1; // [R14]
          end else if (current_privilege_level != 2'h0) begin
            done_d = 1'b1;
            fault_d = VTINV_FLT_GP; // [R15]
          end else if (issue_is_nested || !type_ok) begin
            // Nested main operation lives elsewhere; only its traps are here
            done_d = 1'b1;
            if (!type_ok) begin
              flags_d = current_struct_valid ? 6'h08 : 6'h01; // [R05] [R20]
              err_wr_d = current_struct_valid;
              err_d = ERR_INVALID_OPERAND;
            end
          end else begin
            state_d = VTINV_ST_FETCH;
          end
        end
      end
      VTINV_ST_FETCH: begin
        if (fetch_done) begin
          desc_d = fetch_data; // [R06]
          if (fetch_limit_ss) begin
            state_d = VTINV_ST_IDLE;
            done_d = 1'b1;
            fault_d = VTINV_FLT_SS; // [R17] [R18]
          end else if (fetch_limit_other) begin
            state_d = VTINV_ST_IDLE;
            done_d = 1'b1;
            fault_d = VTINV_FLT_GP; // [R17] [R18]
          end else if (fetch_pf) begin
            state_d = VTINV_ST_IDLE;
            done_d = 1'b1;
            fault_d = VTINV_FLT_PF; // [R16]
            fcode_d = fetch_pf_code;
          end else if (desc_fail) begin
            state_d = VTINV_ST_IDLE;
            done_d = 1'b1;
            flags_d = current_struct_valid ? 6'h08 : 6'h01; // [R20]
            err_wr_d = current_struct_valid;
            err_d = ERR_INVALID_OPERAND;
          end else begin
            state_d = VTINV_ST_INVAL;
          end
        end
      end
      VTINV_ST_INVAL: begin
        // Cache arrays match on tag, plus address for type 0, never on nested pointer or context tag
        if (inval_ack) begin // [R10]
          state_d = VTINV_ST_IDLE;
          done_d = 1'b1;
          flags_d = 6'h00; // [R20]
        end
      end
      default: begin
        state_d = VTINV_ST_IDLE;
      end
    endcase
  end
  always_ff @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= VTINV_ST_IDLE;
      kind_q <= 2'h0;
      desc_q <= 128'h0;
      done_q <= 1'b0;
      vm_exit_q <= 1'b0;
      fault_q <= VTINV_FLT_NONE;
      fcode_q <= 16'h0;
      flags_q <= 6'h0;
      err_wr_q <= 1'b0;
      err_q <= 5'h0;
    end else begin
      state_q <= state_d;
      kind_q <= kind_d;
      desc_q <= desc_d;
      done_q <= done_d;
      vm_exit_q <= vm_exit_d;
      fault_q <= fault_d;
      fcode_q <= fcode_d;
      flags_q <= flags_d;
      err_wr_q <= err_wr_d;
      err_q <= err_d;
    end
  end
  assign fetch_req = (state_q == VTINV_ST_FETCH);
  assign inval_valid = (state_q == VTINV_ST_INVAL); // [R01] [R02] [R03] [R04]
  assign inval_kind = kind_q;
  assign inval_tag = desc_q[TAG_LSB +: TAG_W];
  assign inval_addr = desc_q[LADDR_LSB +: LADDR_W];
  assign done = done_q;
  assign vm_exit = vm_exit_q;
  assign fault = fault_q;
  assign fault_code = fcode_q;
  assign flags_out = flags_q;
  assign err_write = err_wr_q;
  assign err_number = err_q;

  // Steps of one instruction that the properties below are built from
  sequence s_issue_idle;
    state_q == VTINV_ST_IDLE && issue_valid;
  endsequence
  sequence s_root_issue;
    s_issue_idle ##0 (!ud_hit && !guest_mode && current_privilege_level == 2'h0);
  endsequence
  sequence s_fetch_back;
    fetch_req && fetch_done;
  endsequence
  // Clean answer: no fault and a descriptor that passes every check
  sequence s_fetch_clean;
    s_fetch_back ##0 (!fetch_pf && !fetch_limit_ss && !fetch_limit_other && !desc_fail);
  endsequence

  a_ud_first: assert property (@(posedge clock) disable iff (!rst_b) // [R12]
    (state_q == VTINV_ST_IDLE && issue_valid && v86_mode_flag) |=> (fault == VTINV_FLT_UD && done))
    else $error("v86 issue did not fault undefined");
  a_compat_ud: assert property (@(posedge clock) disable iff (!rst_b) // [R13]
    (state_q == VTINV_ST_IDLE && issue_valid && long_mode_active_flag && !cs_long) |=> fault == VTINV_FLT_UD)
    else $error("compatibility mode not refused");
  a_guest_exit: assert property (@(posedge clock) disable iff (!rst_b) // [R14]
    (state_q == VTINV_ST_IDLE && issue_valid && !ud_hit && guest_mode) |=> (vm_exit && !fetch_req))
    else $error("guest issue did not exit");
  a_exit_quiet: assert property (@(posedge clock) disable iff (!rst_b) // [R14]
    s_issue_idle ##0 (!ud_hit && guest_mode) |=> (fault == VTINV_FLT_NONE && !err_write && $stable(flags_out)))
    else $error("guest exit touched flags or faulted");
  a_priv_gp: assert property (@(posedge clock) disable iff (!rst_b) // [R15]
    (state_q == VTINV_ST_IDLE && issue_valid && !ud_hit && !guest_mode && current_privilege_level != 2'h0)
    |=> (fault == VTINV_FLT_GP && fault_code == 16'h0))
    else $error("privilege fault missing");
  a_nest_cap_ud: assert property (@(posedge clock) disable iff (!rst_b) // [R19]
    s_issue_idle ##0 (issue_is_nested && !secondary_ctl_capabilities[CTLS2_NEST_BIT])
    |=> (fault == VTINV_FLT_UD && done))
    else $error("nested invalidate without capability not refused");
  a_tag_cap_ud: assert property (@(posedge clock) disable iff (!rst_b) // [R21]
    s_issue_idle ##0 (!issue_is_nested && !translation_inval_capabilities[CAP_TAGINV_BIT])
    |=> (fault == VTINV_FLT_UD && done))
    else $error("tagged invalidate without capability not refused");
  a_nested_stop: assert property (@(posedge clock) disable iff (!rst_b) // [R19]
    s_root_issue ##0 (issue_is_nested && type_ok)
    |=> (done && !fetch_req && fault == VTINV_FLT_NONE && $stable(flags_out)))
    else $error("nested invalidate went past its traps");
  a_type_nofetch: assert property (@(posedge clock) disable iff (!rst_b) // [R05]
    (state_q == VTINV_ST_IDLE && issue_valid && !ud_hit && !guest_mode
     && current_privilege_level == 2'h0 && !type_ok) |=> (!fetch_req && done && flags_out != 6'h00))
    else $error("unsupported type was fetched");
  a_carry_fail: assert property (@(posedge clock) disable iff (!rst_b) // [R20]
    s_root_issue ##0 (!type_ok && !current_struct_valid) |=> (flags_out == 6'h01 && !err_write))
    else $error("failure without structure did not set carry");
  a_fetch_after_check: assert property (@(posedge clock) disable iff (!rst_b) // [R22]
    s_root_issue ##0 (type_ok && !issue_is_nested) |=> (fetch_req && !done))
    else $error("checked issue did not fetch");
  a_stack_first: assert property (@(posedge clock) disable iff (!rst_b) // [R17]
    s_fetch_back ##0 fetch_limit_ss |=> (fault == VTINV_FLT_SS && done && fault_code == 16'h0))
    else $error("stack fault not raised first");
  a_other_gp: assert property (@(posedge clock) disable iff (!rst_b) // [R18]
    s_fetch_back ##0 (fetch_limit_other && !fetch_limit_ss) |=> (fault == VTINV_FLT_GP && done))
    else $error("segment fault not raised as protection");
  a_pf_code: assert property (@(posedge clock) disable iff (!rst_b) // [R16]
    (fetch_req && fetch_done && fetch_pf && !fetch_limit_ss && !fetch_limit_other)
    |=> (fault == VTINV_FLT_PF && fault_code == $past(fetch_pf_code)))
    else $error("page fault code lost");
  a_rsvd_fail: assert property (@(posedge clock) disable iff (!rst_b) // [R07]
    (fetch_req && fetch_done && !fetch_pf && !fetch_limit_ss && !fetch_limit_other && |fetch_data[63:16])
    |=> (!inval_valid && done))
    else $error("reserved bits not refused");
  a_zero_tag: assert property (@(posedge clock) disable iff (!rst_b) // [R08]
    (fetch_req && fetch_done && fetch_data[15:0] == 16'h0 && kind_q != 2'h2) |=> !inval_valid)
    else $error("zero tag invalidated");
  a_zero_fail: assert property (@(posedge clock) disable iff (!rst_b) // [R20]
    s_fetch_back ##0 (desc_fail && !fetch_pf && !fetch_limit_ss && !fetch_limit_other && current_struct_valid)
    |=> (flags_out == 6'h08 && err_write && err_number == ERR_INVALID_OPERAND))
    else $error("descriptor failure did not set zero and error");
  // Reserved bits are zero on a clean fetch, so the whole word can be rebuilt
  a_inval_fields: assert property (@(posedge clock) disable iff (!rst_b) // [R06]
    s_fetch_clean |=> (inval_valid && {inval_addr, 48'h0, inval_tag} == $past(fetch_data)))
    else $error("invalidate fields differ from descriptor");
  a_inval_hold: assert property (@(posedge clock) disable iff (!rst_b) // [R01]
    (inval_valid && !inval_ack)
    |=> (inval_valid && $stable(inval_kind) && $stable(inval_tag) && $stable(inval_addr)))
    else $error("invalidate request dropped before acknowledge");
  a_success_flags: assert property (@(posedge clock) disable iff (!rst_b) // [R20]
    (inval_valid && inval_ack) |=> (done && flags_out == 6'h00 && !err_write))
    else $error("success flags wrong");
endmodule
`default_nettype wire

// ===== sim/vtinv_pipe_model.sv
// Pipeline-side model: descriptor fetch and invalidation acknowledge
`timescale 1ns/10ps
`default_nettype none
module vtinv_pipe_model #(parameter logic [15:0] PF_CODE = 16'h0b3d) (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic fetch_req,
  input wire logic inval_valid,
  input wire logic [127:0] m_desc,
  input wire logic [2:0] m_cfg,
  input wire logic [1:0] m_lat,
  output logic fetch_done,
  output logic [127:0] fetch_data,
  output logic [2:0] fetch_flt,
  output logic [15:0] fetch_pf_code,
  output logic inval_ack
);
  logic [1:0] fcnt;
  logic [1:0] acnt;
  // Whole 128-bit word per answer; data scrambled outside the pulse
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      {fetch_done, fetch_data, fetch_flt, fetch_pf_code, fcnt} <= '0;
    end else if (fetch_req && !fetch_done && fcnt == m_lat) begin
      fetch_done <= 1'b1;
      fetch_data <= m_desc;
      fetch_flt <= m_cfg;
      fetch_pf_code <= PF_CODE;
      fcnt <= 2'h0;
    end else begin
      fetch_done <= 1'b0;
      fetch_data <= ~fetch_data;
      fetch_flt <= 3'h0;
      fetch_pf_code <= ~fetch_pf_code;
      fcnt <= (fetch_req && !fetch_done) ? fcnt + 2'h1 : 2'h0;
    end
  end
  // Slow acks only when m_lat asks for them
  always @(posedge clock or negedge rst_b) begin
    if (!rst_b) begin
      {inval_ack, acnt} <= '0;
    end else begin
      inval_ack <= inval_valid && !inval_ack && acnt == m_lat;
      acnt <= (inval_valid && !inval_ack && acnt != m_lat) ? acnt + 2'h1 : 2'h0;
    end
  end
endmodule
`default_nettype wire

// ===== sim/vtinv_top_tb.sv
// Self-checking bench for the tagged invalidate block
`timescale 1ns/10ps
`default_nettype none
module vtinv_top_tb;
  import vtinv_pkg::*;
  localparam logic [9:0] E = 10'h2b8;
  localparam logic [15:0] PC = 16'h0b3d;
  localparam logic [9:0] UDM [4] = '{10'h200, 10'h080, 10'h040, 10'h010};
  localparam logic [2:0] FC [4] = '{3'h1, 3'h4, 3'h2, 3'h7};
  localparam vtinv_fault_type FX [4] = '{VTINV_FLT_PF, VTINV_FLT_SS, VTINV_FLT_GP, VTINV_FLT_SS};
  logic clock = 1'b0;
  logic rst_b = 1'b0;
  logic issue_valid = 1'b0;
  logic [9:0] env = E;
  logic [63:0] type_operand = 64'h0;
  logic [63:0] sec = 64'h22_0000_0000;
  logic [63:0] cap = 64'h1_0010_0000;
  logic [3:0] sup = 4'hf;
  logic [127:0] m_desc = 128'h0;
  logic [2:0] m_cfg = 3'h0;
  logic [1:0] m_lat = 2'h0;
  logic [63:0] ga = 64'h7fff_ffff_f000;
  logic [5:0] xf = 6'h0;
  logic [1:0] sk;
  logic [15:0] st;
  logic [63:0] sa;
  int err_total = 0;
  int n_compared = 0;
  int n_inv = 0;
  int n_fetch = 0;
  wire logic vmx_on, guest_mode, protection_enable_flag, v86_mode_flag, long_mode_active_flag, cs_long;
  wire logic current_struct_valid, issue_is_nested, fetch_req, fetch_done, fetch_pf, fetch_limit_ss;
  wire logic fetch_limit_other, inval_valid, inval_ack, done, vm_exit, err_write;
  wire logic [1:0] current_privilege_level, inval_kind;
  wire logic [127:0] fetch_data;
  wire logic [15:0] fetch_pf_code, inval_tag, fault_code;
  wire logic [63:0] inval_addr;
  wire logic [5:0] flags_out;
  wire logic [4:0] err_number;
  wire logic [2:0] flt;
  wire vtinv_fault_type fault;
  assign {vmx_on, guest_mode, protection_enable_flag, v86_mode_flag, long_mode_active_flag, cs_long,
    current_struct_valid, issue_is_nested, current_privilege_level} = env;
  assign {fetch_limit_ss, fetch_limit_other, fetch_pf} = flt;
  vtinv_top dut (.clock, .rst_b, .issue_valid, .issue_is_nested, .type_operand, .vmx_on, .guest_mode,
    .protection_enable_flag, .v86_mode_flag, .long_mode_active_flag, .cs_long, .current_privilege_level,
    .secondary_ctl_capabilities(sec), .translation_inval_capabilities(cap), .type_supported(sup),
    .current_struct_valid, .fetch_req, .fetch_done, .fetch_data, .fetch_pf, .fetch_pf_code, .fetch_limit_ss,
    .fetch_limit_other, .inval_valid, .inval_kind, .inval_tag, .inval_addr, .inval_ack, .done, .vm_exit,
    .fault, .fault_code, .flags_out, .err_write, .err_number);
  vtinv_pipe_model #(.PF_CODE(PC)) pm (.clock, .rst_b, .fetch_req, .inval_valid, .m_desc, .m_cfg, .m_lat,
    .fetch_done, .fetch_data, .fetch_flt(flt), .fetch_pf_code, .inval_ack);
  initial forever #5 clock = ~clock;
  always @(posedge clock) begin
    if (fetch_done === 1'b1) n_fetch++;
    if (inval_valid === 1'b1 && inval_ack === 1'b1) begin
      n_inv++;
      sk = inval_kind;
      st = inval_tag;
      sa = inval_addr;
    end
  end
  task chk(input string nm, input logic [63:0] s, input logic [63:0] x);
    n_compared++;
    if (s !== x) begin
      err_total++;
      $display("Error %s expected %h seen %h", nm, x, s);
    end
  endtask
  task give_verdict();
    $display("compared %0d mismatches %0d", n_compared, err_total);
    if (err_total == 0 && n_compared > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task setc(input logic [63:0] s, input logic [63:0] c, input logic [3:0] t);
    @(posedge clock);
    sec <= s;
    cap <= c;
    sup <= t;
  endtask
  // One instruction; fl 6'h3f means flags left as they were
  task go(input logic [9:0] e, input logic [63:0] ty, input logic [63:0] lo, input logic [2:0] pc,
      input vtinv_fault_type ef, input logic ex, input logic [5:0] fl, input logic iv);
    int k;
    int n0;
    m_desc = {ga, lo};
    m_cfg = pc;
    n0 = n_inv;
    k = 0;
    @(posedge clock);
    env <= e;
    type_operand <= ty;
    issue_valid <= 1'b1;
    @(posedge clock);
    issue_valid <= 1'b0;
    #1;
    while (done !== 1'b1 && k < 30) begin
      @(posedge clock);
      #1;
      k++;
    end
    if (fl != 6'h3f) xf = fl;
    chk("done", done, 1'b1);
    chk("fault", fault, ef);
    chk("exit", vm_exit, ex);
    chk("code", fault_code, ef == VTINV_FLT_PF ? PC : 16'h0);
    chk("errw", err_write, fl == 6'h08);
    if (fl == 6'h08) chk("errn", err_number, ERR_INVALID_OPERAND);
    chk("flags", flags_out, xf);
    chk("invals", n_inv - n0, iv);
    if (iv) chk("inval", {sk, st, sa[45:0]}, {ty[1:0], lo[15:0], ga[45:0]});
  endtask
  initial begin
    #100000;
    err_total++;
    give_verdict();
  end
  initial begin
    repeat (2) @(posedge clock);
    #1 chk("idle", {done, fetch_req, inval_valid, flags_out}, 9'h0);
    rst_b <= 1'b1;
    for (int t = 0; t < 4; t++) go(E, 64'(t), 64'h5, 3'h0, VTINV_FLT_NONE, 1'b0, 6'h0, 1'b1);
    go(E, 64'h2, 64'h0, 3'h0, VTINV_FLT_NONE, 1'b0, 6'h0, 1'b1);
    ga = 64'hffff_8000_0000_0000;
    go(E, 64'h0, 64'h7, 3'h0, VTINV_FLT_NONE, 1'b0, 6'h0, 1'b1);
    ga = 64'h0000_8000_0000_0000;
    go(E, 64'h0, 64'h7, 3'h0, VTINV_FLT_NONE, 1'b0, 6'h08, 1'b0);
    ga = 64'h7fff_ffff_f000;
    for (int t = 0; t < 4; t++) if (t != 2) go(E, 64'(t), 64'h0, 3'h0, VTINV_FLT_NONE, 1'b0, 6'h08, 1'b0);
    go(E, 64'h1, 64'h1_0005, 3'h0, VTINV_FLT_NONE, 1'b0, 6'h08, 1'b0);
    go(E, 64'h2, 64'h8000_0000_0000_0005, 3'h0, VTINV_FLT_NONE, 1'b0, 6'h08, 1'b0);
    $display("test descriptor finished");
    go(E ^ 10'h020, 64'h1_0000_0001, 64'h5, 3'h0, VTINV_FLT_NONE, 1'b0, 6'h0, 1'b1);
    go(E, 64'h1_0000_0001, 64'h5, 3'h0, VTINV_FLT_NONE, 1'b0, 6'h08, 1'b0);
    go(E, 64'h4, 64'h5, 3'h0, VTINV_FLT_NONE, 1'b0, 6'h08, 1'b0);
    setc(64'h22_0000_0000, 64'h1_0010_0000, 4'hd);
    k_fetch_check: begin
      int n;
      n = n_fetch;
      go(E, 64'h1, 64'h5, 3'h0, VTINV_FLT_NONE, 1'b0, 6'h08, 1'b0);
      chk("fetches", n_fetch, n);
    end
    go(E, 64'h0, 64'h5, 3'h0, VTINV_FLT_NONE, 1'b0, 6'h0, 1'b1);
    go(E ^ 10'h008, 64'h4, 64'h5, 3'h0, VTINV_FLT_NONE, 1'b0, 6'h01, 1'b0);
    $display("test types finished");
    foreach (UDM[i]) go(E ^ UDM[i], 64'h1, 64'h5, 3'h0, VTINV_FLT_UD, 1'b0, 6'h3f, 1'b0);
    go(E ^ 10'h140, 64'h1, 64'h5, 3'h0, VTINV_FLT_UD, 1'b0, 6'h3f, 1'b0);
    go(E ^ 10'h103, 64'h1, 64'h5, 3'h0, VTINV_FLT_NONE, 1'b1, 6'h3f, 1'b0);
    go(E ^ 10'h003, 64'h1, 64'h5, 3'h0, VTINV_FLT_GP, 1'b0, 6'h3f, 1'b0);
    setc(64'h2_0000_0000, 64'h1_0010_0000, 4'hf);
    go(E, 64'h1, 64'h5, 3'h0, VTINV_FLT_UD, 1'b0, 6'h3f, 1'b0);
    go(E ^ 10'h004, 64'h1, 64'h5, 3'h0, VTINV_FLT_NONE, 1'b0, 6'h3f, 1'b0);
    setc(64'h22_0000_0000, 64'h10_0000, 4'hf);
    go(E, 64'h1, 64'h5, 3'h0, VTINV_FLT_UD, 1'b0, 6'h3f, 1'b0);
    setc(64'h20_0000_0000, 64'h1_0010_0000, 4'hf);
    go(E ^ 10'h004, 64'h1, 64'h5, 3'h0, VTINV_FLT_UD, 1'b0, 6'h3f, 1'b0);
    setc(64'h22_0000_0000, 64'h1_0000_0000, 4'hf);
    go(E ^ 10'h004, 64'h1, 64'h5, 3'h0, VTINV_FLT_UD, 1'b0, 6'h3f, 1'b0);
    setc(64'h22_0000_0000, 64'h1_0010_0000, 4'hf);
    $display("test opcode checks finished");
    m_lat = 2'h2;
    foreach (FC[i]) go(E, 64'h1, 64'h1_0000, FC[i], FX[i], 1'b0, 6'h3f, 1'b0);
    go(E, 64'h3, 64'h9, 3'h0, VTINV_FLT_NONE, 1'b0, 6'h0, 1'b1);
    $display("test fetch faults finished");
    give_verdict();
  end
endmodule
`default_nettype wire
